// *** verilog/spp_defines.svh ***
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define SPP_IDX_CONTROL 8'hBC
`define SPP_IDX_STATUS 8'hBD
`define SPP_IDX_DATA 8'hBE

// ============================================================
// Reset values.
`define SPP_CONTROL_RESET 8'h00
`define SPP_FLAGS_RESET 5'h00
`define SPP_DATA_RESET 8'h00
`define SPP_PRDATA_RESET 32'h0000_0000

// ============================================================
// Serial timing: sixteen clock edges per byte, divider counts.
`define SPP_EDGE_RESET 5'h00
`define SPP_EDGE_STEP 5'h01
`define SPP_EDGE_LAST 5'h0F
`define SPP_EDGE_DONE 5'h10
`define SPP_DIV_RESET 4'h0
`define SPP_DIV_STEP 4'h1
`define SPP_HALF_LAST_DIV2 4'h0
`define SPP_HALF_LAST_DIV4 4'h1
`define SPP_HALF_LAST_DIV8 4'h3
`define SPP_HALF_LAST_DIV16 4'h7

// ============================================================
// Rate codes and bus widths.
`define SPP_RATE_DIV2 2'h0
`define SPP_RATE_DIV4 2'h1
`define SPP_RATE_DIV8 2'h2
`define SPP_RATE_DIV16 2'h3
`define SPP_ADDR_W 12
`define SPP_DATA_W 32
`define SPP_SYNC_W 4

`endif

// *** verilog/spp_pkg.sv ***
`default_nettype none

package spp_pkg;

    // ============================================================
    // Control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic port_enable;
        logic master_select;
        logic clock_idle_level;
        logic clock_phase_second;
        logic select_check_off;
        logic low_bit_first;
        logic [1:0] serial_rate_select;
    } spp_ctrl_s;

    // ============================================================
    // Sticky status flags, status bits 7 down to 3.
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic receive_overrun_flag;
        logic receive_full_flag;
    } spp_flags_s;

    typedef enum logic [1:0] {
        SPP_IDLE = 2'b01,
        SPP_SHIFT = 2'b10
    } spp_phase_e;

    // ============================================================
    // APB request and answer.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } spp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spp_apb_rsp_s;

    // ============================================================
    // Serial pins: inputs and output/enable pairs.
    typedef struct packed {
        logic sck_in;
        logic mosi_in;
        logic miso_in;
        logic ss_n_in;
    } spp_pin_in_s;

    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
    } spp_pin_out_s;

endpackage

`default_nettype wire

// *** verilog/spp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for the serial pin inputs.
module spp_sync
    import spp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire spp_pin_in_s async_in,
    output spp_pin_in_s sync_out
);

    typedef struct packed {
        spp_pin_in_s first;
        spp_pin_in_s second;
    } spp_sync_state_s;

    spp_sync_state_s state_reg;
    spp_sync_state_s state_next;

    always_comb begin
        state_next.first = async_in;
        state_next.second = state_reg.first;
    end

    // The select pin idles high, so it resets high to avoid a false select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= {4'h1, 4'h1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;

endmodule // spp_sync

`default_nettype wire

// *** verilog/spp_port.sv ***
// Functional notes
// R1 - Port is idle while enable bit is 0, works when it is 1.
// R2 - Master-select bit picks slave when 0, master when 1.
// R3 - Clock polarity bit sets idle level of the serial clock.
// R4 - Clock phase bit samples data on first or second clock edge.
// R5 - Select-check-off bit ignores the select pin when 1.
// R6 - Bit-order bit sends most significant bit first, or least when 1.
// R7 - Master clock is system clock over 2, 4, 8 or 16.
// R8 - Transfer-done flag sets at transfer end and requests the interrupt.
// R9 - Transfer-done flag clears on interrupt vectoring or software writing 0.
// R10 - Write-collision flag sets on data write while busy.
// R11 - Write-collision clears on writing 0 or a data write while idle.
// R12 - Mode fault sets when master, checking on and select pin low.
// R13 - Mode fault clears port enable and master-select bits.
// R14 - Overrun sets when transfer ends with buffer still full; cleared by 0 or read.
// R15 - Buffer-full sets at transfer end; cleared by writing 0 or data read.
// R16 - Busy flag reads 1 during a transfer, else 0.
// R17 - Data write loads the shift register; in master mode starts a transfer.
// R18 - Data read returns the receive buffer, not the shift register.
// R19 - Each transfer exchanges eight bits, sending and receiving together.
// R20 - External master drives the clock and holds select low throughout.
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"

module spp_port
    import spp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire spp_apb_req_s apb_req,
    output spp_apb_rsp_s apb_rsp,
    input wire spp_pin_in_s pin_in,
    output spp_pin_out_s pin_out,
    input wire logic irq_vector_ack,
    output logic irq_request
);

    // ============================================================
    // State
    typedef struct packed {
        spp_ctrl_s ctrl;
        spp_flags_s flags;
        spp_phase_e phase;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [7:0] rx_buffer;
        logic [4:0] edge_count;
        logic [3:0] div_count;
        logic sck_level;
        logic sck_seen;
        logic out_bit;
        logic miso_drive;
        logic [1:0] smp_dly;
        logic [1:0] fin_dly;
        logic [31:0] prdata;
    } spp_state_s;

    spp_state_s state_reg;
    spp_state_s state_next;
    spp_pin_in_s pin_sync;

    spp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ============================================================
    // Decoding helpers
    function automatic logic spp_hit(input logic [11:0] addr, input logic [7:0] idx);
        return addr == {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [3:0] spp_half_last(input logic [1:0] rate);
        case (rate)
            `SPP_RATE_DIV2: spp_half_last = `SPP_HALF_LAST_DIV2;
            `SPP_RATE_DIV4: spp_half_last = `SPP_HALF_LAST_DIV4;
            `SPP_RATE_DIV8: spp_half_last = `SPP_HALF_LAST_DIV8;
            default: spp_half_last = `SPP_HALF_LAST_DIV16;
        endcase
    endfunction

    function automatic logic [7:0] spp_status_byte(input spp_flags_s f, input logic busy);
        return {f.transfer_done_flag, f.write_collision_flag, f.mode_fault_flag,
                f.receive_overrun_flag, f.receive_full_flag, busy, 2'b00};
    endfunction

    // ============================================================
    // Next-state logic
    always_comb begin
        logic setup;
        logic access;
        logic wr_ctrl;
        logic wr_stat;
        logic wr_data;
        logic rd_data;
        logic enabled;
        logic master;
        logic selected;
        logic busy;
        logic sck_edge;
        logic edge_go;
        logic leading;
        logic sample;
        logic in_bit;
        logic smp_now;
        logic finish;
        logic abort;
        logic start;
        logic done_ev;
        logic full_ev;
        logic ovf_ev;
        logic mode_fault_flag_ev;
        logic write_collision_flag_ev;
        logic [7:0] rx_new;
        logic [7:0] read_mux;

        state_next = state_reg;
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable;
        wr_ctrl = access && apb_req.pwrite && spp_hit(apb_req.paddr, `SPP_IDX_CONTROL);
        wr_stat = access && apb_req.pwrite && spp_hit(apb_req.paddr, `SPP_IDX_STATUS);
        wr_data = access && apb_req.pwrite && spp_hit(apb_req.paddr, `SPP_IDX_DATA);
        rd_data = access && !apb_req.pwrite && spp_hit(apb_req.paddr, `SPP_IDX_DATA);
        // R1 port enable
        enabled = state_reg.ctrl.port_enable;
        // R2 mode select
        master = state_reg.ctrl.master_select;
        // R5 select pin use
        selected = state_reg.ctrl.select_check_off || !pin_sync.ss_n_in;
        // R16 busy flag
        busy = (state_reg.phase == SPP_SHIFT);
        sck_edge = pin_sync.sck_in ^ state_reg.sck_seen;
        state_next.sck_seen = pin_sync.sck_in;
        start = 1'b0;
        finish = 1'b0;
        abort = 1'b0;
        done_ev = 1'b0;
        full_ev = 1'b0;
        ovf_ev = 1'b0;
        mode_fault_flag_ev = 1'b0;
        write_collision_flag_ev = 1'b0;
        edge_go = 1'b0;
        leading = 1'b0;
        sample = 1'b0;
        in_bit = 1'b0;
        smp_now = 1'b0;
        rx_new = state_reg.rx_shift;

        // ========================================================
        // Software clears of the sticky flags
        if (wr_stat) begin
            // R9 write zero clears
            state_next.flags.transfer_done_flag = state_reg.flags.transfer_done_flag
                && apb_req.pwdata[7];
            // R11 write zero clears
            state_next.flags.write_collision_flag = state_reg.flags.write_collision_flag
                && apb_req.pwdata[6];
            // R12 write zero clears
            state_next.flags.mode_fault_flag = state_reg.flags.mode_fault_flag
                && apb_req.pwdata[5];
            // R14 write zero clears
            state_next.flags.receive_overrun_flag = state_reg.flags.receive_overrun_flag
                && apb_req.pwdata[4];
            // R15 write zero clears
            state_next.flags.receive_full_flag = state_reg.flags.receive_full_flag
                && apb_req.pwdata[3];
        end
        // R9 cleared on vectoring
        if (irq_vector_ack) begin
            state_next.flags.transfer_done_flag = 1'b0;
        end
        // R14 read clears overrun
        if (rd_data) begin
            state_next.flags.receive_overrun_flag = 1'b0;
            // R15 read clears full
            state_next.flags.receive_full_flag = 1'b0;
        end
        if (wr_ctrl) begin
            state_next.ctrl = apb_req.pwdata[7:0];
        end

        // ========================================================
        // Data register writes
        if (wr_data) begin
            if (busy) begin
                // R10 collision on busy
                write_collision_flag_ev = 1'b1;
            end else begin
                // R11 clean rewrite clears
                state_next.flags.write_collision_flag = 1'b0;
                // R17 load shift register
                state_next.tx_shift = apb_req.pwdata[7:0];
                // R17 master write starts
                start = enabled && master;
            end
        end

        // ========================================================
        // Serial engine
        // R12 mode fault detect
        if (enabled && master && !state_reg.ctrl.select_check_off && !pin_sync.ss_n_in) begin
            mode_fault_flag_ev = 1'b1;
            abort = 1'b1;
            start = 1'b0;
        end
        if (!enabled) begin
            abort = 1'b1;
        end
        // R20 select dropped mid-byte
        if (enabled && !master && busy && !selected) begin
            abort = 1'b1;
        end

        if (!abort) begin
            if (master) begin
                if (busy && state_reg.edge_count != `SPP_EDGE_DONE) begin
                    // R7 clock divider
                    if (state_reg.div_count == spp_half_last(state_reg.ctrl.serial_rate_select)) begin
                        state_next.div_count = `SPP_DIV_RESET;
                        edge_go = 1'b1;
                    end else begin
                        state_next.div_count = state_reg.div_count + `SPP_DIV_STEP;
                    end
                end
            end else begin
                edge_go = selected && sck_edge;
            end
        end

        if (edge_go) begin
            leading = !state_reg.edge_count[0];
            // R4 sample edge choice
            sample = state_reg.ctrl.clock_phase_second ? !leading : leading;
            if (!sample && state_reg.edge_count != `SPP_EDGE_RESET) begin
                // R6 transmit bit order
                state_next.tx_shift = state_reg.ctrl.low_bit_first
                    ? {1'b0, state_reg.tx_shift[7:1]} : {state_reg.tx_shift[6:0], 1'b0};
            end
            if (master) begin
                state_next.sck_level = !state_reg.sck_level;
            end
            state_next.edge_count = state_reg.edge_count + `SPP_EDGE_STEP;
            state_next.phase = SPP_SHIFT;
            // R19 eight bits per byte
            finish = !master && (state_reg.edge_count == `SPP_EDGE_LAST);
        end

        // The master reads its data line two cycles late, once it has passed the synchroniser.
        state_next.smp_dly = {state_reg.smp_dly[0], sample && master};
        state_next.fin_dly = {state_reg.fin_dly[0],
            edge_go && master && (state_reg.edge_count == `SPP_EDGE_LAST)};
        smp_now = master ? state_reg.smp_dly[1] : sample;
        finish = finish || (master && !abort && state_reg.fin_dly[1]);
        in_bit = master ? pin_sync.miso_in : pin_sync.mosi_in;
        if (smp_now) begin
            // R6 receive bit order
            rx_new = state_reg.ctrl.low_bit_first ? {in_bit, state_reg.rx_shift[7:1]}
                : {state_reg.rx_shift[6:0], in_bit};
            state_next.rx_shift = rx_new;
        end

        case (state_reg.phase)
            SPP_IDLE: begin
                // R3 idle clock level
                state_next.sck_level = state_reg.ctrl.clock_idle_level;
                if (start) begin
                    state_next.phase = SPP_SHIFT;
                    state_next.div_count = `SPP_DIV_RESET;
                    state_next.edge_count = `SPP_EDGE_RESET;
                end
            end
            SPP_SHIFT: begin
                if (abort) begin
                    state_next.phase = SPP_IDLE;
                end
            end
            default: begin
                state_next.phase = SPP_IDLE;
            end
        endcase

        if (abort) begin
            state_next.edge_count = `SPP_EDGE_RESET;
            state_next.div_count = `SPP_DIV_RESET;
            state_next.sck_level = state_reg.ctrl.clock_idle_level;
            state_next.smp_dly = 2'b00;
            state_next.fin_dly = 2'b00;
        end

        if (finish) begin
            state_next.phase = SPP_IDLE;
            state_next.edge_count = `SPP_EDGE_RESET;
            state_next.rx_buffer = rx_new;
            // R8 done at end
            done_ev = 1'b1;
            // R15 buffer full at end
            full_ev = 1'b1;
            // R14 overrun when still full
            ovf_ev = state_next.flags.receive_full_flag;
        end

        // ========================================================
        // Hardware sets win over clears
        state_next.flags.transfer_done_flag = state_next.flags.transfer_done_flag || done_ev;
        state_next.flags.receive_full_flag = state_next.flags.receive_full_flag || full_ev;
        state_next.flags.receive_overrun_flag = state_next.flags.receive_overrun_flag || ovf_ev;
        state_next.flags.write_collision_flag = state_next.flags.write_collision_flag || write_collision_flag_ev;
        state_next.flags.mode_fault_flag = state_next.flags.mode_fault_flag || mode_fault_flag_ev;
        if (mode_fault_flag_ev) begin
            // R13 fault drops enable
            state_next.ctrl.port_enable = 1'b0;
            state_next.ctrl.master_select = 1'b0;
        end

        // R6 first bit presented
        state_next.out_bit = state_next.ctrl.low_bit_first ? state_next.tx_shift[0]
            : state_next.tx_shift[7];
        state_next.miso_drive = state_next.ctrl.port_enable && !state_next.ctrl.master_select
            && (state_next.ctrl.select_check_off || !pin_sync.ss_n_in);

        // ========================================================
        // Read data captured in the setup phase
        read_mux = 8'h00;
        if (spp_hit(apb_req.paddr, `SPP_IDX_CONTROL)) begin
            read_mux = state_reg.ctrl;
        end else if (spp_hit(apb_req.paddr, `SPP_IDX_STATUS)) begin
            read_mux = spp_status_byte(state_reg.flags, busy);
        end else if (spp_hit(apb_req.paddr, `SPP_IDX_DATA)) begin
            // R18 read receive buffer
            read_mux = state_reg.rx_buffer;
        end
        if (setup) begin
            state_next.prdata = {24'h00_0000, read_mux};
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.ctrl <= `SPP_CONTROL_RESET;
            state_reg.flags <= `SPP_FLAGS_RESET;
            state_reg.phase <= SPP_IDLE;
            state_reg.tx_shift <= `SPP_DATA_RESET;
            state_reg.rx_shift <= `SPP_DATA_RESET;
            state_reg.rx_buffer <= `SPP_DATA_RESET;
            state_reg.edge_count <= `SPP_EDGE_RESET;
            state_reg.div_count <= `SPP_DIV_RESET;
            state_reg.sck_level <= 1'b0;
            state_reg.sck_seen <= 1'b0;
            state_reg.out_bit <= 1'b0;
            state_reg.miso_drive <= 1'b0;
            state_reg.smp_dly <= 2'b00;
            state_reg.fin_dly <= 2'b00;
            state_reg.prdata <= `SPP_PRDATA_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ============================================================
    // Outputs
    logic addr_known;

    assign addr_known = spp_hit(apb_req.paddr, `SPP_IDX_CONTROL)
        || spp_hit(apb_req.paddr, `SPP_IDX_STATUS)
        || spp_hit(apb_req.paddr, `SPP_IDX_DATA);

    assign apb_rsp.prdata = state_reg.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_known;

    // Master drives clock and data out; a slave drives only its data line.
    assign pin_out.sck_out = state_reg.sck_level;
    assign pin_out.sck_oe = state_reg.ctrl.port_enable && state_reg.ctrl.master_select;
    assign pin_out.mosi_out = state_reg.out_bit;
    assign pin_out.mosi_oe = state_reg.ctrl.port_enable && state_reg.ctrl.master_select;
    assign pin_out.miso_out = state_reg.out_bit;
    assign pin_out.miso_oe = state_reg.miso_drive;

    // R8 interrupt request
    assign irq_request = state_reg.flags.transfer_done_flag;

endmodule // spp_port

`default_nettype wire

// *** sim/spp_port_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"

module spp_port_assertions
    import spp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire spp_apb_req_s apb_req,
    input wire spp_apb_rsp_s apb_rsp,
    input wire spp_pin_in_s pin_in,
    input wire spp_pin_out_s pin_out,
    input wire logic irq_vector_ack,
    input wire logic irq_request
);
    // ============================================================
    // Shadow of the control register, taken from bus writes.
    logic [7:0] ctrl_reg;
    logic wr_ctrl;
    assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == {2'b00, `SPP_IDX_CONTROL, 2'b00};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 8'h00;
        end else if (wr_ctrl) begin
            ctrl_reg <= apb_req.pwdata[7:0];
        end
    end
    // ============================================================
    // Properties.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_master_on;
        wr_ctrl && apb_req.pwdata[7:6] == 2'b11;
    endsequence
    sequence s_slow_edge;
        $changed(pin_out.sck_out) && pin_out.sck_oe && ctrl_reg[1:0] == 2'h3;
    endsequence
    a_off_quiet: assert property (wr_ctrl && !apb_req.pwdata[7] |-> ##2
        !pin_out.sck_oe && !pin_out.mosi_oe && !pin_out.miso_oe) else $error("pins driven");
    a_master_drive: assert property (s_master_on |-> ##2
        pin_out.sck_oe && pin_out.mosi_oe) else $error("master pins idle");
    a_slave_quiet: assert property (wr_ctrl && apb_req.pwdata[7:6] == 2'b10 |-> ##2
        !pin_out.sck_oe && !pin_out.mosi_oe) else $error("slave drives clock");
    a_oe_pair: assert property (pin_out.sck_oe |-> pin_out.mosi_oe && !pin_out.miso_oe)
        else $error("enables disagree");
    a_idle_level: assert property (s_master_on |-> ##2
        pin_out.sck_out == $past(apb_req.pwdata[5], 2)) else $error("clock idle level");
    a_fault_stop: assert property ($fell(pin_in.ss_n_in) && pin_out.sck_oe && !ctrl_reg[3]
        |-> ##[1:5] !pin_out.sck_oe) else $error("fault kept master");
    a_ack_clear: assert property (irq_vector_ack |-> ##[1:2] !irq_request)
        else $error("request kept");
    a_slow_gap: assert property (s_slow_edge |=> $stable(pin_out.sck_out) [*7])
        else $error("clock half period");
endmodule // spp_port_assertions

bind spp_port spp_port_assertions u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out), .irq_vector_ack(irq_vector_ack),
    .irq_request(irq_request));

`default_nettype wire

// *** sim/spp_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Serial slave on the far side; records clock edge times.
module spp_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic idle_hi,
    input wire logic phase2,
    input wire logic low_first,
    input wire logic load,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got,
    output longint t_first,
    output longint t_last
);
    int n = 0;
    int edges = 0;
    initial miso = 1'b1;
    always @(posedge load) begin
        n = 0;
        edges = 0;
        got = 8'h00;
        miso = reply[low_first ? 0 : 7] ^ phase2;
    end
    always @(sck) begin
        edges++;
        if (edges == 1) t_first = $time;
        t_last = $time;
        if ((sck != idle_hi) ^ phase2) begin
            got[low_first ? n : 7 - n] = mosi;
            n++;
        end else if (n < 8) begin
            miso = reply[low_first ? n : 7 - n];
        end else begin
            miso = ~miso;
        end
    end
endmodule // spp_slave_model

`default_nettype wire

// *** sim/spp_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "spp_defines.svh"

module spp_port_tb
    import spp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, ack, ss_n, load, e, irq, miso;
    logic [7:0] reply, cfg, c, got;
    logic [4:0] m;
    logic [31:0] r;
    longint t0, t1;
    int fails = 0, checks = 0, seed = 19;
    spp_apb_req_s req;
    spp_apb_rsp_s rsp;
    spp_pin_in_s pin;
    spp_pin_out_s pout;

    always #20 pclk = ~pclk;
    assign pin = {1'b0, 1'b0, miso, ss_n};
    spp_port dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pin_in(pin),
        .pin_out(pout), .irq_vector_ack(ack), .irq_request(irq));
    spp_slave_model p (.sck(pout.sck_out), .mosi(pout.mosi_out), .idle_hi(cfg[5]),
        .phase2(cfg[4]), .low_first(cfg[2]), .load(load), .reply(reply), .miso(miso),
        .got(got), .t_first(t0), .t_last(t1));

    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            fails++;
            $display("Error at %0t: read %h, expected %h", $time, g, x);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic x);
        cmp_reg({31'h0, g}, {31'h0, x});
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h0, wd}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1) begin
            fails++;
            print_verdict();
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic chk_st;
        apb(1'b0, `SPP_IDX_STATUS, 8'h00);
        cmp_reg(r, {24'h0, m, 3'b000});
    endtask
    task automatic xfer(input logic rd, input logic coll);
        logic [7:0] tx;
        int n;
        repeat (6) @(posedge pclk);
        tx = 8'($random(seed));
        reply <= 8'($random(seed));
        cfg <= c;
        apb(1'b1, `SPP_IDX_CONTROL, c);
        repeat (2) @(posedge pclk);
        load <= 1'b1;
        apb(1'b1, `SPP_IDX_DATA, tx);
        load <= 1'b0;
        m[3] = coll;
        if (coll) apb(1'b1, `SPP_IDX_DATA, ~tx);
        n = 0;
        do begin
            apb(1'b0, `SPP_IDX_STATUS, 8'h00);
            n++;
        end while (r[2] !== 1'b0 && n < 200);
        if (n >= 200) begin
            fails++;
            print_verdict();
        end
        m = {1'b1, m[3:2], m[1] | m[0], 1'b1};
        cmp_bit(n > 1, 1'b1);
        cmp_reg(r, {24'h0, m, 3'b000});
        cmp_bit(irq, 1'b1);
        cmp_reg({24'h0, got}, {24'h0, tx});
        cmp_reg(32'((t1 - t0) / 600), 32'h1 << c[1:0]);
        if (rd) begin
            apb(1'b0, `SPP_IDX_DATA, 8'h00);
            cmp_reg(r, {24'h0, reply});
            m[1:0] = 2'b00;
        end
    endtask

    initial begin
        presetn = 1'b0;
        req = '0;
        ack = 1'b0;
        ss_n = 1'b1;
        load = 1'b0;
        reply = 8'h00;
        cfg = 8'h00;
        m = 5'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            apb(1'b0, 8'(`SPP_IDX_CONTROL + a), 8'h00);
            cmp_reg(r, 32'h0);
        end
        apb(1'b1, 8'hBF, 8'hFF);
        cmp_bit(e, 1'b1);
        apb(1'b0, 8'hBF, 8'h00);
        cmp_reg({r[31:1], e}, 32'h1);
        $display("Test reset finished");
        for (int a = 0; a < 2; a++) begin
            apb(1'b1, `SPP_IDX_CONTROL, a ? 8'h80 : 8'h40);
            apb(1'b1, `SPP_IDX_DATA, 8'hA5);
            chk_st();
            apb(1'b0, `SPP_IDX_DATA, 8'h00);
            cmp_reg(r, 32'h0);
        end
        $display("Test no start finished");
        for (int i = 0; i < 8; i++) begin
            c = {2'b11, 4'($random(seed)), 2'(i)};
            xfer(i != 3, i == 5);
        end
        $display("Test transfers finished");
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        m[4] = 1'b0;
        chk_st();
        cmp_bit(irq, 1'b0);
        c = 8'hC0;
        xfer(1'b0, 1'b1);
        apb(1'b1, `SPP_IDX_STATUS, 8'h7F);
        m = m & 5'h0F;
        chk_st();
        apb(1'b1, `SPP_IDX_STATUS, 8'h00);
        m = 5'h00;
        chk_st();
        $display("Test flag clearing finished");
        apb(1'b1, `SPP_IDX_CONTROL, 8'hC1);
        ss_n <= 1'b0;
        repeat (6) @(posedge pclk);
        m[2] = 1'b1;
        chk_st();
        apb(1'b0, `SPP_IDX_CONTROL, 8'h00);
        cmp_reg(r, 32'h01);
        ss_n <= 1'b1;
        apb(1'b1, `SPP_IDX_STATUS, 8'hDF);
        m[2] = 1'b0;
        chk_st();
        apb(1'b1, `SPP_IDX_CONTROL, 8'hC9);
        ss_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk_st();
        apb(1'b0, `SPP_IDX_CONTROL, 8'h00);
        cmp_reg(r, 32'hC9);
        $display("Test select pin finished");
        print_verdict();
    end
endmodule // spp_port_tb

`default_nettype wire
